/* File: hw/bmx_exec.sv */
`timescale 1ns/1ps
module bmx_exec
   import bmx_pkg::*;
(
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   // Command port.
   input  wire logic                  start,
   input  wire bmx_pkg::bmx_op_e      op,
   input  wire logic                  width_word,
   input  wire logic                  step_sign,
   input  wire logic                  seg_override,
   input  wire logic [15:0]           override_seg,
   output logic                       busy,
   output logic                       done,
   // Register file values.
   input  wire logic [15:0]           source_index,
   input  wire logic [15:0]           dest_index_reg,
   input  wire logic [15:0]           source_segment_default,
   input  wire logic [15:0]           dest_segment_base,
   input  wire logic [15:0]           accumulator_word,
   input  wire logic [15:0]           operand_a,
   input  wire logic [15:0]           operand_b,
   input  wire logic                  carry_flag_in,
   input  wire logic                  overflow_flag_in,
   // Results.
   output logic [15:0]                source_index_out,
   output logic [15:0]                dest_index_out,
   output logic [15:0]                accumulator_out,
   output logic [15:0]                high_product_word,
   output logic [15:0]                product_out,
   output logic                       carry_flag,
   output logic                       overflow_flag,
   // Memory port, one access at a time.
   output logic                       mem_req,
   output logic                       mem_we,
   output logic                       mem_word,
   output logic [BMX_ADDR_W-1:0]      mem_addr,
   output logic [15:0]                mem_wdata,
   input  wire logic                  mem_ack,
   input  wire logic [15:0]           mem_rdata
);
   import bmx_pkg::*;

   typedef enum logic [1:0] {BMX_IDLE, BMX_READ, BMX_WRITE} bmx_state_e;

   bmx_state_e       st_r, st_nxt;
   logic [15:0]      six_r, six_nxt, dix_r, dix_nxt, sseg_r, sseg_nxt, dseg_r, dseg_nxt;
   logic             word_r, word_nxt, sign_r, sign_nxt;
   logic [15:0]      acc_r, acc_nxt, hi_r, hi_nxt, prod_r, prod_nxt;
   logic             cy_r, cy_nxt, ov_r, ov_nxt, done_r, done_nxt;
   logic [15:0]      step;
   logic             buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
   logic [16:0]      buf_out_data;
   logic signed [15:0] sb_prod;
   logic signed [31:0] sw_prod;
   logic [15:0]      ub_prod;
   logic [31:0]      uw_prod;
   logic signed [31:0] sw_acc_full;
   logic [15:0]        sw_prod_acc, sw_prod_hi;
   logic               sw_flag;

   // Read data passes through the buffer so a stalled write loses no element.
   bmx_buf #(.WIDTH(17), .DEPTH(BMX_BUF_DEPTH)) u_buf (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   ({word_r, mem_rdata}),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   // Products; signed forms sign-extend operands, unsigned forms zero-extend them.
   assign sb_prod = $signed(accumulator_word[7:0]) * $signed(operand_a[7:0]);
   assign sw_prod = $signed(operand_a) * $signed(operand_b);
   assign ub_prod = {8'h00, accumulator_word[7:0]} * {8'h00, operand_a[7:0]};
   assign uw_prod = {16'h0000, accumulator_word} * {16'h0000, operand_a};

   // Word signed multiply of accumulator and operand, split into its two halves.
   assign sw_acc_full = $signed(accumulator_word) * $signed(operand_a);
   assign sw_prod_acc = sw_acc_full[15:0];
   assign sw_prod_hi  = sw_acc_full[31:16];
   assign sw_flag     = (sw_acc_full[31:16] != {16{sw_acc_full[15]}});

   // Element size; direction is applied where the indices update.
   assign step = word_r ? BMX_STEP_WORD : BMX_STEP_BYTE;

   assign buf_in_valid  = (st_r == BMX_READ) && mem_ack;
   assign buf_out_ready = (st_r == BMX_WRITE) && mem_ack;
   assign busy          = (st_r != BMX_IDLE);
   assign done          = done_r;
   assign mem_req       = (st_r == BMX_READ && buf_in_ready) || (st_r == BMX_WRITE && buf_out_valid);
   assign mem_we        = (st_r == BMX_WRITE);
   assign mem_word      = word_r;
   // Source in its own segment, destination always in the destination base.
   assign mem_addr      = (st_r == BMX_WRITE) ?
                          (BMX_ADDR_W'(dseg_r) << BMX_SEG_SHIFT) + BMX_ADDR_W'(dix_r) :
                          (BMX_ADDR_W'(sseg_r) << BMX_SEG_SHIFT) + BMX_ADDR_W'(six_r);
   assign mem_wdata     = buf_out_data[15:0];
   assign source_index_out  = six_r;
   assign dest_index_out    = dix_r;
   assign accumulator_out   = acc_r;
   assign high_product_word = hi_r;
   assign product_out       = prod_r;
   assign carry_flag        = cy_r;
   assign overflow_flag     = ov_r;

   // Sequencing and result computation.
   always_comb begin
      st_nxt   = st_r;
      six_nxt  = six_r;
      dix_nxt  = dix_r;
      sseg_nxt = sseg_r;
      dseg_nxt = dseg_r;
      word_nxt = word_r;
      sign_nxt = sign_r;
      acc_nxt  = acc_r;
      hi_nxt   = hi_r;
      prod_nxt = prod_r;
      cy_nxt   = cy_r;
      ov_nxt   = ov_r;
      done_nxt = 1'b0;
      unique case (st_r)
         BMX_IDLE: begin
            if (start) begin
               cy_nxt  = carry_flag_in;
               ov_nxt  = overflow_flag_in;
               acc_nxt = accumulator_word;
               unique case (op)
                  BMX_OP_COPY, BMX_OP_COPY_BYTE, BMX_OP_COPY_WORD: begin
                     st_nxt   = BMX_READ;
                     six_nxt  = source_index;
                     dix_nxt  = dest_index_reg;
                     sign_nxt = step_sign;
                     dseg_nxt = dest_segment_base;
                     sseg_nxt = seg_override ? override_seg : source_segment_default;
                     word_nxt = (op == BMX_OP_COPY_WORD) ||
                                ((op == BMX_OP_COPY) && width_word);
                  end
                  BMX_OP_MUL1: begin
                     done_nxt = 1'b1;
                     if (width_word) begin
                        acc_nxt = sw_prod_acc;
                        hi_nxt  = sw_prod_hi;
                        cy_nxt  = sw_flag;
                        ov_nxt  = sw_flag;
                     end else begin
                        acc_nxt = sb_prod;
                        cy_nxt  = (sb_prod[15:8] != {8{sb_prod[7]}});
                        ov_nxt  = (sb_prod[15:8] != {8{sb_prod[7]}});
                     end
                  end
                  BMX_OP_MUL2, BMX_OP_MUL3: begin
                     done_nxt = 1'b1;
                     prod_nxt = sw_prod[15:0];
                     cy_nxt   = (sw_prod[31:16] != {16{sw_prod[15]}});
                     ov_nxt   = (sw_prod[31:16] != {16{sw_prod[15]}});
                  end
                  BMX_OP_UNSIGNED_PRODUCT_OP: begin
                     done_nxt = 1'b1;
                     if (width_word) begin
                        acc_nxt = uw_prod[15:0];
                        hi_nxt  = uw_prod[31:16];
                        cy_nxt  = (uw_prod[31:16] != 16'h0000);
                        ov_nxt  = (uw_prod[31:16] != 16'h0000);
                     end else begin
                        acc_nxt = ub_prod;
                        cy_nxt  = (ub_prod[15:8] != 8'h00);
                        ov_nxt  = (ub_prod[15:8] != 8'h00);
                     end
                  end
                  default: done_nxt = 1'b1;
               endcase
            end
         end
         BMX_READ: begin
            if (buf_in_valid) begin
               st_nxt = BMX_WRITE;
            end
         end
         BMX_WRITE: begin
            if (buf_out_ready && buf_out_valid) begin
               st_nxt   = BMX_IDLE;
               done_nxt = 1'b1;
               six_nxt  = sign_r ? six_r - step : six_r + step;
               dix_nxt  = sign_r ? dix_r - step : dix_r + step;
            end
         end
      endcase
   end

   // State and result registers only.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r   <= BMX_IDLE;
         six_r  <= BMX_RST_WORD;
         dix_r  <= BMX_RST_WORD;
         sseg_r <= BMX_RST_WORD;
         dseg_r <= BMX_RST_WORD;
         word_r <= 1'b0;
         sign_r <= 1'b0;
         acc_r  <= BMX_RST_WORD;
         hi_r   <= BMX_RST_WORD;
         prod_r <= BMX_RST_WORD;
         cy_r   <= 1'b0;
         ov_r   <= 1'b0;
         done_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         six_r  <= six_nxt;
         dix_r  <= dix_nxt;
         sseg_r <= sseg_nxt;
         dseg_r <= dseg_nxt;
         word_r <= word_nxt;
         sign_r <= sign_nxt;
         acc_r  <= acc_nxt;
         hi_r   <= hi_nxt;
         prod_r <= prod_nxt;
         cy_r   <= cy_nxt;
         ov_r   <= ov_nxt;
         done_r <= done_nxt;
      end
   end
endmodule // bmx_exec

/* File: hw/bmx_pkg.sv */
package bmx_pkg;
   // Operation codes presented on the command port.
   typedef enum logic [2:0] {
      BMX_OP_COPY      = 3'h0,
      BMX_OP_COPY_BYTE = 3'h1,
      BMX_OP_COPY_WORD = 3'h2,
      BMX_OP_MUL1      = 3'h3,
      BMX_OP_MUL2      = 3'h4,
      BMX_OP_MUL3      = 3'h5,
      BMX_OP_UNSIGNED_PRODUCT_OP      = 3'h6
   } bmx_op_e;

   localparam int          BMX_DATA_W   = 16;
   localparam int          BMX_ADDR_W   = 20;
   localparam int          BMX_SEG_SHIFT = 4;
   localparam int          BMX_BUF_DEPTH = 2;
   localparam logic [15:0] BMX_STEP_BYTE = 16'h0001;
   localparam logic [15:0] BMX_STEP_WORD = 16'h0002;
   localparam logic [15:0] BMX_RST_WORD  = 16'h0000;
endpackage

/* File: hw/bmx_buf.sv */
`timescale 1ns/1ps
// Small valid/ready buffer that holds read data while the write side stalls.
module bmx_buf #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 2
) (
   input  wire logic             clock,
   input  wire logic             arst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [PW-1:0]    rd_r, rd_nxt, wr_r, wr_nxt;
   logic [PW:0]      cnt_r, cnt_nxt;
   logic             push, pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and storage next state.
   always_comb begin
      mem_nxt = mem_r;
      rd_nxt  = rd_r;
      wr_nxt  = wr_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wr_r] = in_data;
         wr_nxt        = (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
         rd_nxt = (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
   end

   // Registers only.
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         rd_r  <= '0;
         wr_r  <= '0;
         cnt_r <= '0;
      end else begin
         mem_r <= mem_nxt;
         rd_r  <= rd_nxt;
         wr_r  <= wr_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule // bmx_buf

/* File: tb/bmx_exec_assertions.sv */
`timescale 1ns/1ps
// Checks memory addressing, result timing and some product values at the block's ports.
module bmx_exec_chk
   import bmx_pkg::*;
(
   input logic                          clock,
   input logic                          arst_n,
   input logic                          start,
   input bmx_pkg::bmx_op_e              op,
   input logic                          width_word,
   input logic                          seg_override,
   input logic [15:0]                   override_seg,
   input logic                          busy,
   input logic                          done,
   input logic [15:0]                   source_index,
   input logic [15:0]                   dest_index_reg,
   input logic [15:0]                   source_segment_default,
   input logic [15:0]                   dest_segment_base,
   input logic [15:0]                   accumulator_word,
   input logic [15:0]                   operand_a,
   input logic [15:0]                   accumulator_out,
   input logic [15:0]                   high_product_word,
   input logic                          carry_flag,
   input logic                          mem_req,
   input logic                          mem_we,
   input logic                          mem_ack,
   input logic [bmx_pkg::BMX_ADDR_W-1:0] mem_addr
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic [7:0] acc_lo;
   logic [7:0] opa_lo;
   logic       take;
   // Low bytes and the accepted-command strobe feed the result checks.
   assign acc_lo = accumulator_word[7:0];
   assign opa_lo = operand_a[7:0];
   assign take = start && !busy;
   a_req_in_copy: assert property (mem_req |-> busy)
      else $error("Memory request outside a copy.");
   a_dest_addr: assert property (mem_req && mem_we |->
      mem_addr == {dest_segment_base, 4'h0} + {4'h0, dest_index_reg})
      else $error("Write address not in destination segment.");
   a_src_addr: assert property (mem_req && !mem_we |-> mem_addr ==
      {(seg_override ? override_seg : source_segment_default), 4'h0} + {4'h0, source_index})
      else $error("Read address not in source segment.");
   a_copy_done: assert property (mem_req && mem_we && mem_ack |=> done)
      else $error("Copy did not finish after write.");
   a_done_single: assert property (done |=> !done)
      else $error("Done held longer than one cycle.");
   a_mul_answer: assert property (take && op inside {BMX_OP_MUL1, BMX_OP_MUL2,
      BMX_OP_MUL3, BMX_OP_UNSIGNED_PRODUCT_OP} |=> done) else $error("Multiply result late.");
   a_unsigned_product_op_byte: assert property (take && op == BMX_OP_UNSIGNED_PRODUCT_OP && !width_word |=>
      accumulator_out == $past(acc_lo) * $past(opa_lo) &&
      carry_flag == (accumulator_out[15:8] != 8'h00)) else $error("Unsigned byte product wrong.");
   a_mul_word: assert property (take && op == BMX_OP_MUL1 && width_word |=>
      $signed({high_product_word, accumulator_out}) ==
      $signed($past(accumulator_word)) * $signed($past(operand_a)))
      else $error("Signed word product wrong.");
endmodule // bmx_exec_chk

bind bmx_exec bmx_exec_chk bmx_exec_chk_i (.clock, .arst_n, .start, .op, .width_word,
   .seg_override, .override_seg, .busy, .done, .source_index, .dest_index_reg,
   .source_segment_default, .dest_segment_base, .accumulator_word, .operand_a,
   .accumulator_out, .high_product_word, .carry_flag, .mem_req, .mem_we, .mem_ack, .mem_addr);

/* File: tb/tb_bmx_exec.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_bmx_exec;
   import bmx_pkg::*;
   logic clock = 0, arst_n = 0, start = 0, width_word = 0, step_sign = 0, seg_override = 0;
   bmx_op_e op = BMX_OP_COPY;
   logic [15:0] override_seg = 0, source_index = 0, dest_index_reg = 0, operand_a = 0;
   logic [15:0] source_segment_default = 0, dest_segment_base = 0, accumulator_word = 0;
   logic [15:0] operand_b = 0, mem_rdata = 0, rd_val = 0, wr_data;
   logic [15:0] source_index_out, dest_index_out, accumulator_out, high_product_word;
   logic [15:0] product_out, mem_wdata;
   logic carry_flag_in = 0, overflow_flag_in = 0, mem_ack = 0, wr_word;
   logic busy, done, carry_flag, overflow_flag, mem_req, mem_we, mem_word;
   logic [BMX_ADDR_W-1:0] mem_addr, rd_addr, wr_addr;
   int fail_count = 0, checks = 0, cycles = 0, stall = 0, wait_n = 0;
   bmx_exec bmx_exec_i (.clock, .arst_n, .start, .op, .width_word, .step_sign, .seg_override,
      .override_seg, .busy, .done, .source_index, .dest_index_reg, .source_segment_default,
      .dest_segment_base, .accumulator_word, .operand_a, .operand_b, .carry_flag_in,
      .overflow_flag_in, .source_index_out, .dest_index_out, .accumulator_out,
      .high_product_word, .product_out, .carry_flag, .overflow_flag, .mem_req, .mem_we,
      .mem_word, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
   // Clock generator.
   always #12.5 clock = ~clock;
   // Memory side: acknowledges after the chosen stall, otherwise shows a changing pattern.
   always @(posedge clock) begin
      logic a;
      #1;
      a = (mem_req === 1'b1) && (wait_n >= stall);
      wait_n = a || mem_req !== 1'b1 ? 0 : wait_n + 1;
      if (a && mem_we) begin wr_addr = mem_addr; wr_data = mem_wdata; wr_word = mem_word; end
      if (a && !mem_we) rd_addr = mem_addr;
      mem_rdata = (a && !mem_we) ? rd_val : ~mem_rdata;
      mem_ack = a;
      cycles++;
      if (cycles == 6000) begin fail_count++; complete_run(); end
   end
   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Waits a bounded time for the completion pulse.
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 60) begin @(posedge clock); #1; n++; end
      `CHK(done, 1'b1);
   endtask
   // Issues one command pulse and waits for completion.
   task automatic run_op(input bmx_op_e o);
      @(posedge clock); #1;
      op = o; start = 1;
      @(posedge clock); #1; start = 0;
      wait_done();
   endtask
   // Copies one element with a given variant, direction, override and stall.
   task automatic sc_copy(input logic [2:0] i);
      bmx_op_e o; logic w; logic [15:0] stp, esi, edi; logic [19:0] ra, wa;
      o = i[2:1] == 2'd1 ? BMX_OP_COPY_BYTE : i[2:1] == 2'd2 ? BMX_OP_COPY_WORD : BMX_OP_COPY;
      width_word = i[0]; step_sign = i[1] ^ i[0]; seg_override = i[2]; stall = 32'(i);
      w = (o == BMX_OP_COPY) ? i[0] : (o == BMX_OP_COPY_WORD);
      source_index = 16'hFFFE + 16'(i); dest_index_reg = 16'h0001 - 16'(i);
      carry_flag_in = i[0]; overflow_flag_in = ~i[0]; rd_val = 16'hC3A5 ^ 16'(i);
      stp = w ? BMX_STEP_WORD : BMX_STEP_BYTE;
      esi = step_sign ? source_index - stp : source_index + stp;
      edi = step_sign ? dest_index_reg - stp : dest_index_reg + stp;
      ra = {(seg_override ? override_seg : source_segment_default), 4'h0} + {4'h0, source_index};
      wa = {dest_segment_base, 4'h0} + {4'h0, dest_index_reg};
      rd_addr = 'x; wr_addr = 'x;
      run_op(o);
      `CHK(rd_addr, ra);
      `CHK(wr_addr, wa);
      `CHK(wr_word, w);
      `CHK(w ? wr_data : {8'h00, wr_data[7:0]}, w ? rd_val : {8'h00, rd_val[7:0]});
      `CHK({source_index_out, dest_index_out}, {esi, edi});
      `CHK({carry_flag, overflow_flag}, {i[0], ~i[0]});
   endtask
   // Signed accumulator multiply, byte or word.
   task automatic sc_signed(input logic ww, input logic [15:0] acc, input logic [15:0] a);
      logic signed [31:0] pw; logic signed [15:0] pb; logic ov;
      width_word = ww; accumulator_word = acc; operand_a = a;
      pw = $signed(acc) * $signed(a);
      pb = $signed(acc[7:0]) * $signed(a[7:0]);
      ov = ww ? pw[31:16] != {16{pw[15]}} : pb[15:8] != {8{pb[7]}};
      run_op(BMX_OP_MUL1);
      if (ww) `CHK({high_product_word, accumulator_out}, pw)
      else `CHK(accumulator_out, pb)
      `CHK({carry_flag, overflow_flag}, {ov, ov});
   endtask
   // Two- and three-operand signed multiply with an immediate.
   task automatic sc_imm(input bmx_op_e o, input logic [15:0] a, input logic [15:0] b);
      logic signed [31:0] pw; logic ov;
      operand_a = a; operand_b = b; pw = $signed(a) * $signed(b);
      ov = pw[31:16] != {16{pw[15]}};
      run_op(o);
      `CHK({product_out, carry_flag, overflow_flag}, {pw[15:0], ov, ov});
   endtask
   // Unsigned accumulator multiply, byte or word.
   task automatic sc_unsigned(input logic ww, input logic [15:0] acc, input logic [15:0] a);
      logic [31:0] pw; logic [15:0] pb; logic ov;
      width_word = ww; accumulator_word = acc; operand_a = a;
      pw = acc * a; pb = acc[7:0] * a[7:0];
      ov = ww ? pw[31:16] != 16'h0000 : pb[15:8] != 8'h00;
      run_op(BMX_OP_UNSIGNED_PRODUCT_OP);
      if (ww) `CHK({high_product_word, accumulator_out}, pw)
      else `CHK(accumulator_out, pb)
      `CHK({carry_flag, overflow_flag}, {ov, ov});
   endtask
   // A multiply command offered during a copy must be ignored.
   task automatic sc_refuse();
      logic [15:0] keep;
      // The copy loads the accumulator as it stands; a taken multiply would give FE01.
      keep = 16'h00FF; stall = 5; accumulator_word = keep; operand_a = 16'h00FF;
      width_word = 0;
      @(posedge clock); #1; op = BMX_OP_COPY; start = 1;
      @(posedge clock); #1; start = 0;
      @(posedge clock); #1; op = BMX_OP_UNSIGNED_PRODUCT_OP; start = 1;
      @(posedge clock); #1; start = 0;
      wait_done();
      `CHK(accumulator_out, keep);
   endtask
   // Main sequence.
   initial begin
      override_seg = 16'hABCD; source_segment_default = 16'h1234; dest_segment_base = 16'h5678;
      repeat (4) @(posedge clock);
      #1 arst_n = 1;
      for (int i = 0; i < 8; i++) sc_copy(3'(i));
      sc_signed(0, 16'hABF6, 16'h770C);
      sc_signed(0, 16'h0040, 16'h0004);
      sc_signed(1, 16'hFFFF, 16'hFFFF);
      sc_signed(1, 16'h4000, 16'h0002);
      sc_imm(BMX_OP_MUL2, 16'hFF00, 16'h0080);
      sc_imm(BMX_OP_MUL2, 16'h0100, 16'h0100);
      sc_imm(BMX_OP_MUL3, 16'h0100, 16'h0100);
      sc_imm(BMX_OP_MUL3, 16'hFFF0, 16'h0010);
      sc_unsigned(0, 16'h55F6, 16'h330C);
      sc_unsigned(0, 16'h000F, 16'h0010);
      sc_unsigned(1, 16'hFFFF, 16'hFFFF);
      sc_unsigned(1, 16'h0100, 16'h00FF);
      sc_refuse();
      complete_run();
   end
endmodule // tb_bmx_exec
